// *** rtl/pllg_guard.sv ***
`timescale 1ns/1ps
`include "pllg_consts.svh"

module pllg_guard
	import pllg_pkg::*;
#(
	parameter int COARSE_CNT = `PLLG_COARSE_CNT_DEF,
	parameter int FINE_CNT   = `PLLG_FINE_CNT_DEF,
	parameter int ERR_W      = `PLLG_ERR_W
) (
	// Clock and reset.
	input  wire logic             mclk_i,
	input  wire logic             reset_i,
	// Analog loop side.
	input  wire logic             ref_tick_i,
	input  wire logic [ERR_W-1:0] freq_err_i,
	input  wire logic [ERR_W-1:0] trk_tol_i,
	input  wire logic [ERR_W-1:0] lock_tol_i,
	// Mode and software accesses.
	input  wire logic             auto_mode_i,
	input  wire logic             manual_trk_wr_i,
	input  wire logic             manual_trk_val_i,
	input  wire pllg_ctl_acc_t    ctl_acc_i,
	// Break control from the system integration unit.
	input  wire logic             break_i,
	input  wire logic             break_clear_enable_i,
	// Status.
	output logic                  tracking_state_bit_o,
	output logic                  lock_o,
	output logic                  lock_change_flag_o,
	output logic                  irq_o,
	input  wire logic             irq_en_i
);
	localparam int CNT_W = `PLLG_CNT_W;

	pllg_state_t state_ff;
	pllg_state_t nxt_state;
	logic        manual_trk_ff;
	logic        lock_int;
	logic        lock_prev_ff;
	logic        flag_ff;
	logic        win_done;
	logic        win_inside;
	logic [CNT_W-1:0] win_len;
	logic [ERR_W-1:0] win_tol;
	logic        win_clear;
	logic        ctl_access;
	logic        clear_ok;

	// Elaboration refuses settle counts that the tick counter cannot hold.
	if (COARSE_CNT < 2 || FINE_CNT < 2 || COARSE_CNT >= (1 << CNT_W)
		|| FINE_CNT >= (1 << CNT_W))
	begin : g_bad_count
		$error("pllg_guard: settle counts out of range");
	end

	// ------------------------------------------------------------------
	// Bandwidth state machine
	// ------------------------------------------------------------------
	// The averager window length follows the phase being checked.
	assign win_len   = (state_ff == PLLG_ACQ) ? CNT_W'(COARSE_CNT)
		: CNT_W'(FINE_CNT);
	assign win_tol   = (state_ff == PLLG_ACQ) ? trk_tol_i : lock_tol_i;
	assign win_clear = !auto_mode_i || (state_ff != nxt_state);

	pllg_avg #(
		.ERR_W (ERR_W),
		.CNT_W (CNT_W)
	) u_avg (
		.mclk_i   (mclk_i),
		.reset_i  (reset_i),
		.clear_i  (win_clear),
		.tick_i   (ref_tick_i),
		.len_i    (win_len),
		.err_i    (freq_err_i),
		.tol_i    (win_tol),
		.done_o   (win_done),
		.inside_o (win_inside)
	);

	// Next state; a failed window in lock drops back to tracking, one in tracking back to acquisition.
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			PLLG_ACQ:
			begin
				if (win_done && win_inside)
					nxt_state = PLLG_TRK;
			end
			PLLG_TRK:
			begin
				if (win_done)
					nxt_state = win_inside ? PLLG_LOCK : PLLG_ACQ;
			end
			PLLG_LOCK:
			begin
				if (win_done && !win_inside)
					nxt_state = PLLG_TRK;
			end
			default:
				nxt_state = PLLG_ACQ;
		endcase
		if (!auto_mode_i)
			nxt_state = PLLG_ACQ;
	end

	// State register; reset always restarts in acquisition.
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			state_ff <= PLLG_ACQ;
		else
			state_ff <= nxt_state;
	end

	// Manual value is kept while automatic mode runs and returns after.
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			manual_trk_ff <= 1'b0;
		else if (!auto_mode_i && manual_trk_wr_i)
			manual_trk_ff <= manual_trk_val_i;
	end

	assign lock_int = auto_mode_i && (nxt_state == PLLG_LOCK);

	// ------------------------------------------------------------------
	// Status outputs
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			tracking_state_bit_o <= 1'b0;
			lock_o               <= 1'b0;
		end
		else
		begin
			tracking_state_bit_o <= auto_mode_i ? (nxt_state != PLLG_ACQ)
				: (manual_trk_wr_i ? manual_trk_val_i : manual_trk_ff);
			lock_o <= lock_int;
		end
	end

	// ------------------------------------------------------------------
	// Lock-change flag with break protection
	// ------------------------------------------------------------------
	// Clearing is simply blocked while protected, so nothing needs
	// restoring when break ends; a cleared flag stays cleared.
	assign ctl_access = ctl_acc_i.rd || ctl_acc_i.wr;
	assign clear_ok   = ctl_access && (!break_i || break_clear_enable_i);

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			lock_prev_ff <= 1'b0;
			flag_ff      <= 1'b0;
		end
		else
		begin
			lock_prev_ff <= lock_int;
			if (!auto_mode_i)
				flag_ff <= 1'b0;
			else if (lock_int != lock_prev_ff)
				flag_ff <= 1'b1;
			else if (clear_ok)
				flag_ff <= 1'b0;
		end
	end

	// Output copies come from flops so the pins never glitch.
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			lock_change_flag_o <= 1'b0;
			irq_o              <= 1'b0;
		end
		else
		begin
			lock_change_flag_o <= flag_ff;
			irq_o              <= flag_ff && irq_en_i && auto_mode_i;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	property p_protect;
		@(posedge mclk_i) disable iff (reset_i)
		(break_i && !break_clear_enable_i && flag_ff && auto_mode_i
		&& lock_int == lock_prev_ff) |=> flag_ff;
	endproperty
	a_protect: assert property (p_protect) else $error("flag lost in break");

	property p_bce_clear;
		@(posedge mclk_i) disable iff (reset_i)
		(break_i && break_clear_enable_i && ctl_access
		&& lock_int == lock_prev_ff) |=> !flag_ff;
	endproperty
	a_bce_clear: assert property (p_bce_clear) else $error("break clear failed");

	property p_stay_clear;
		@(posedge mclk_i) disable iff (reset_i)
		($fell(break_i) && !flag_ff && lock_int == lock_prev_ff) |-> ##1 !flag_ff;
	endproperty
	a_stay_clear: assert property (p_stay_clear) else $error("flag restored");

	property p_clear;
		@(posedge mclk_i) disable iff (reset_i)
		(!break_i && ctl_access && lock_int == lock_prev_ff) |=> !flag_ff;
	endproperty
	a_clear: assert property (p_clear) else $error("access did not clear");

	property p_set;
		@(posedge mclk_i) disable iff (reset_i)
		(auto_mode_i && lock_int != lock_prev_ff) |=> flag_ff ##1 lock_change_flag_o;
	endproperty
	a_set: assert property (p_set) else $error("flag not set");

	property p_manual;
		@(posedge mclk_i) disable iff (reset_i)
		!auto_mode_i |=> !lock_o && !flag_ff;
	endproperty
	a_manual: assert property (p_manual) else $error("manual status wrong");

	property p_trk;
		@(posedge mclk_i) disable iff (reset_i)
		(auto_mode_i && state_ff == PLLG_ACQ && win_done && win_inside)
		|=> tracking_state_bit_o;
	endproperty
	a_trk: assert property (p_trk) else $error("tracking not entered");

	property p_lock;
		@(posedge mclk_i) disable iff (reset_i)
		(auto_mode_i && state_ff == PLLG_TRK && win_done && win_inside) |=> lock_o;
	endproperty
	a_lock: assert property (p_lock) else $error("lock not set");

	property p_lock_window;
		@(posedge mclk_i) disable iff (reset_i)
		$rose(state_ff == PLLG_LOCK) |-> $past(win_done);
	endproperty
	a_lock_window: assert property (p_lock_window) else $error("lock off window");

	c_lock:  cover property (@(posedge mclk_i) disable iff (reset_i) $rose(lock_o));
	c_unlck: cover property (@(posedge mclk_i) disable iff (reset_i) $fell(lock_o));
	c_brk:   cover property (@(posedge mclk_i) disable iff (reset_i)
		break_i && ctl_access && flag_ff);
endmodule // pllg_guard

// *** rtl/pllg_consts.svh ***
`ifndef PLLG_CONSTS_SVH
`define PLLG_CONSTS_SVH

// Default settle counts, in reference ticks per measurement window.
`define PLLG_COARSE_CNT_DEF 32
`define PLLG_FINE_CNT_DEF   64
// Width of the tick counters.
`define PLLG_CNT_W          16
// Width of a frequency error sample from the analog side.
`define PLLG_ERR_W          12
// Default tolerances, as absolute error limits.
`define PLLG_TRK_TOL_DEF    12'h040
`define PLLG_LOCK_TOL_DEF   12'h010

`endif

// *** rtl/pllg_pkg.sv ***
package pllg_pkg;
	typedef enum logic [2:0]
	{
		PLLG_ACQ  = 3'h1,
		PLLG_TRK  = 3'h2,
		PLLG_LOCK = 3'h4
	} pllg_state_t;

	// Software access strobes on the loop control register.
	typedef struct packed
	{
		logic rd;
		logic wr;
	} pllg_ctl_acc_t;
endpackage

// *** rtl/pllg_avg.sv ***
`timescale 1ns/1ps
`include "pllg_consts.svh"

// ----------------------------------------------------------------------
// Window averager
// ----------------------------------------------------------------------
// Accumulates the absolute error over a window of ticks and reports
// whether the mean lies inside the tolerance. Comparing the sum against
// tolerance times length avoids a divider.
module pllg_avg #(
	parameter int ERR_W = `PLLG_ERR_W,
	parameter int CNT_W = `PLLG_CNT_W
) (
	// Clock and reset.
	input  wire logic             mclk_i,
	input  wire logic             reset_i,
	// Control.
	input  wire logic             clear_i,
	input  wire logic             tick_i,
	input  wire logic [CNT_W-1:0] len_i,
	input  wire logic [ERR_W-1:0] err_i,
	input  wire logic [ERR_W-1:0] tol_i,
	// Result.
	output logic                  done_o,
	output logic                  inside_o
);
	localparam int SUM_W = ERR_W + CNT_W;

	logic [CNT_W-1:0] cnt_ff;
	logic [SUM_W-1:0] sum_ff;
	logic [SUM_W-1:0] nxt_sum;
	logic [SUM_W-1:0] limit;

	// Elaboration refuses widths that the counter and the sum cannot serve.
	if (ERR_W < 1 || CNT_W < 2)
	begin : g_bad_width
		$error("pllg_avg: bad widths");
	end

	assign nxt_sum = sum_ff + SUM_W'(err_i);
	assign limit   = SUM_W'(tol_i) * SUM_W'(len_i);

	// Counts ticks; the window closes on the len-th tick.
	always_ff @(posedge mclk_i)
	begin
		if (reset_i || clear_i)
		begin
			cnt_ff   <= '0;
			sum_ff   <= '0;
			done_o   <= 1'b0;
			inside_o <= 1'b0;
		end
		else
		begin
			done_o <= 1'b0;
			if (tick_i)
			begin
				if (cnt_ff == len_i - CNT_W'(1))
				begin
					done_o   <= 1'b1;
					inside_o <= (nxt_sum <= limit);
					cnt_ff   <= '0;
					sum_ff   <= '0;
				end
				else
				begin
					cnt_ff <= cnt_ff + CNT_W'(1);
					sum_ff <= nxt_sum;
				end
			end
		end
	end
endmodule // pllg_avg

// *** verification/tb_pllg_guard.sv ***
`timescale 1ns/1ps

module tb_pllg_guard
	import pllg_pkg::*;
;
	// ------------------------------------------------------------
	// Stimulus and observation
	// ------------------------------------------------------------
	logic          mclk_i;
	logic          reset_i;
	logic          ref_tick_i;
	logic [11:0]   freq_err_i;
	logic [11:0]   trk_tol_i;
	logic [11:0]   lock_tol_i;
	logic          auto_mode_i;
	logic          manual_trk_wr_i;
	logic          manual_trk_val_i;
	pllg_ctl_acc_t ctl_acc_i;
	logic          break_i;
	logic          break_clear_enable_i;
	logic          irq_en_i;
	logic          trk_o;
	logic          lock_o;
	logic          flag_o;
	logic          irq_o;
	int            mismatches;
	int            checks;
	int            cycles;
	logic [31:0]   rnd;
	int            sum;
	// Both windows are this many ticks long in the bench.
	localparam int WIN = 4;

	// Short windows keep the run brief; expectations use the same values.
	pllg_guard #(.COARSE_CNT(WIN), .FINE_CNT(WIN), .ERR_W(12)) uut (
		.mclk_i(mclk_i), .reset_i(reset_i), .ref_tick_i(ref_tick_i),
		.freq_err_i(freq_err_i), .trk_tol_i(trk_tol_i), .lock_tol_i(lock_tol_i),
		.auto_mode_i(auto_mode_i), .manual_trk_wr_i(manual_trk_wr_i),
		.manual_trk_val_i(manual_trk_val_i), .ctl_acc_i(ctl_acc_i),
		.break_i(break_i), .break_clear_enable_i(break_clear_enable_i),
		.tracking_state_bit_o(trk_o), .lock_o(lock_o),
		.lock_change_flag_o(flag_o), .irq_o(irq_o), .irq_en_i(irq_en_i));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Xorshift keeps the random stream repeatable from one fixed seed.
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	// A window passes when its mean error is within the tolerance.
	function automatic logic mean_ok(input int total, input int tol);
		return (total <= tol * WIN);
	endfunction

	// Pulses the manual tracking write for one cycle, then lets status settle.
	task automatic mwr(input logic v);
		@(posedge mclk_i);
		manual_trk_wr_i <= 1'b1;
		manual_trk_val_i <= v;
		@(posedge mclk_i);
		manual_trk_wr_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		#1;
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One tick with its error sample; the gap lets status settle before a check.
	task automatic tick(input logic [11:0] e);
		@(posedge mclk_i);
		ref_tick_i <= 1'b1;
		freq_err_i <= e;
		@(posedge mclk_i);
		ref_tick_i <= 1'b0;
		rnd = xs(rnd);
		freq_err_i <= rnd[11:0];
		repeat (6 + rnd[13:12]) @(posedge mclk_i);
		#1;
	endtask

	task automatic acc(input logic rd, input logic wr);
		@(posedge mclk_i);
		ctl_acc_i <= '{rd: rd, wr: wr};
		@(posedge mclk_i);
		ctl_acc_i <= '0;
		repeat (3) @(posedge mclk_i);
		#1;
	endtask

	// ------------------------------------------------------------
	// Clock, reset and hang guard
	// ------------------------------------------------------------
	initial
	begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end

	// The whole sequence needs well under a thousand cycles.
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		{reset_i, ref_tick_i, auto_mode_i, manual_trk_wr_i} = 4'h8;
		{manual_trk_val_i, break_i, break_clear_enable_i, irq_en_i} = 4'h1;
		freq_err_i = 12'h000;
		trk_tol_i = 12'h040;
		lock_tol_i = 12'h010;
		ctl_acc_i = '0;
		mismatches = 0;
		checks = 0;
		cycles = 0;
		rnd = 32'hA04A2AAF;
		repeat (3) @(posedge mclk_i);
		reset_i <= 1'b0;
		auto_mode_i <= 1'b1;
		#1;
		chk(trk_o, 1'b0);
		chk(lock_o, 1'b0);
		chk(flag_o, 1'b0);
		// Mean just above the tracking limit keeps acquisition.
		tick(12'h000);
		tick(12'h000);
		tick(12'h000);
		tick(12'h101);
		chk(trk_o, mean_ok(32'h101, 32'h040));
		// Single samples above the limit but a passing mean; no early exit.
		tick(12'h000);
		tick(12'h080);
		tick(12'h000);
		chk(trk_o, 1'b0);
		tick(12'h07F);
		chk(trk_o, mean_ok(32'h0FF, 32'h040));
		// Random small errors fill three ticks of the fine window; their sum feeds the expectation.
		sum = 0;
		repeat (3)
		begin
			rnd = xs(rnd);
			sum += rnd[3:0];
			tick({8'h00, rnd[3:0]});
		end
		chk(lock_o, 1'b0);
		tick(12'h010);
		chk(lock_o, mean_ok(sum + 32'h010, 32'h010));
		chk(flag_o, 1'b1);
		chk(irq_o, 1'b1);
		// Protected break: accesses leave the flag alone.
		@(posedge mclk_i);
		break_i <= 1'b1;
		acc(1'b1, 1'b0);
		acc(1'b1, 1'b1);
		chk(flag_o, 1'b1);
		@(posedge mclk_i);
		break_clear_enable_i <= 1'b1;
		acc(1'b1, 1'b0);
		chk(flag_o, 1'b0);
		@(posedge mclk_i);
		break_i <= 1'b0;
		break_clear_enable_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		#1;
		chk(flag_o, 1'b0);
		// Failing fine window drops lock; the flag sets with the interrupt disabled.
		@(posedge mclk_i);
		irq_en_i <= 1'b0;
		repeat (4) tick(12'h011);
		chk(lock_o, 1'b0);
		chk(trk_o, 1'b1);
		chk(flag_o, 1'b1);
		chk(irq_o, 1'b0);
		acc(1'b0, 1'b1);
		chk(flag_o, 1'b0);
		// A manual write in automatic mode is refused and must not be stored.
		mwr(1'b1);
		chk(trk_o, 1'b1);
		// Manual mode: no lock, no flag, stored tracking value back, bit writable.
		@(posedge mclk_i);
		auto_mode_i <= 1'b0;
		irq_en_i <= 1'b1;
		repeat (4) tick(12'h000);
		chk(lock_o, 1'b0);
		chk(flag_o, 1'b0);
		chk(irq_o, 1'b0);
		chk(trk_o, 1'b0);
		for (int i = 0; i < 2; i++)
		begin
			mwr(~i[0]);
			chk(trk_o, ~i[0]);
		end
		stop_test();
	end
endmodule // tb_pllg_guard
